// ==== core/sms_standby_seq.sv ====
// Standby mode sequencer: software and hardware standby entry and exit
//
// Contract
// [R01] Sleep with soft enable stops clock, resets modules
// [R02] Wake interrupt starts oscillator, waits, then interrupts
// [R03] Settle select chooses wait length per table
// [R04] Crystal: software picks wait of 8 ms
// [R05] Half-clock external clock: any setting allowed
// [R06] Full-rate clock: never program the 4-state setting
// [R07] Edge select chooses falling or rising NMI
// [R08] Rising select: next rising NMI ends standby
// [R09] Ports keep direction and level in soft standby
// [R10] Standby pin low enters hardware standby at once
// [R11] Hardware standby halts and resets all but RAM
// [R12] Hardware standby releases all ports to high impedance
// [R13] Mode pins stay constant during hardware standby
// [R14] Software clears RAM enable before standby pin falls
// [R15] Standby pin high with reset low starts oscillator
// [R16] Reset held low until oscillator settles
// [R17] Reset rise starts reset handling, then execution
// [R18] Entry: reset low first, then standby pin low
// [R19] Exit: standby high, settle, then reset high
// [R20] Wait counter loads on wake, releases at zero
//
// Local design decisions: the address-and-strobe port and the address map.
`include "sms_cfg.svh"
`timescale 1ns/100ps

module sms_standby_seq #(
	parameter int unsigned WAIT_SEL0 = `SMS_WAIT_SEL0,
	parameter int unsigned WAIT_SEL1 = `SMS_WAIT_SEL1,
	parameter int unsigned WAIT_SEL2 = `SMS_WAIT_SEL2,
	parameter int unsigned WAIT_SEL3 = `SMS_WAIT_SEL3,
	parameter int unsigned WAIT_SEL4 = `SMS_WAIT_SEL4,
	parameter int unsigned WAIT_SEL6 = `SMS_WAIT_SEL6
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [`SMS_AW-1:0] regAddr,
	input wire logic [`SMS_DW-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [`SMS_DW-1:0] regRdata,
	input wire logic sleepExec,
	input wire logic [2:0] irqEnable,
	input wire logic nmiPin,
	input wire logic [2:0] irqPinN,
	input wire logic hw_sleep_pin_n,
	input wire logic chip_init_pin_n,
	output sms_pkg::sms_state_t modeState,
	output logic clockRun,
	output logic oscEnable,
	output logic cpuHalt,
	output logic dmaReset,
	output logic moduleReset,
	output logic ioHold,
	output logic ioRelease,
	output logic ramHold,
	output logic intExcStart,
	output logic resetExcStart
);
	import sms_pkg::*;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [`SMS_SYNC_W-1:0] pinMeta_reg;
	logic [`SMS_SYNC_W-1:0] pinSync_reg;
	logic nmiPrev_reg;
	wire [`SMS_SYNC_W-1:0] pinRaw = {chip_init_pin_n, hw_sleep_pin_n, irqPinN, nmiPin};

	always_ff @(posedge sys_clk) begin
		pinMeta_reg <= pinRaw;
		pinSync_reg <= pinMeta_reg;
		nmiPrev_reg <= pinSync_reg[0];
	end

	wire nmiLevel = pinSync_reg[0];
	wire [2:0] irqActive = ~pinSync_reg[3:1] & irqEnable;
	wire hwPinHigh = pinSync_reg[4];
	wire initPinHigh = pinSync_reg[5];

	// ************************************************************
	// Control register
	// ************************************************************
	logic [`SMS_DW-1:0] ctrl_reg;
	logic [`SMS_DW-1:0] ctrl_next;
	logic [`SMS_DW-1:0] regRdata_reg;
	sms_state_t state_reg;
	sms_state_t state_next;

	wire ctrlHit = (regAddr == `SMS_OFF_CTRL);
	wire statHit = (regAddr == `SMS_OFF_STAT);
	wire soft_sleep_enable = ctrl_reg[`SMS_B_SOFT_SLEEP];
	wire nmi_edge_select = ctrl_reg[`SMS_B_NMI_EDGE];
	wire onchip_ram_enable = ctrl_reg[`SMS_B_RAM_EN];
	wire sms_settle_sel_t settle_time_select = ctrl_reg[`SMS_F_SETTLE_HI:`SMS_F_SETTLE_LO];
	wire [`SMS_DW-1:0] statWord = {2'h0, state_reg};
	wire [`SMS_DW-1:0] rdMux = ctrlHit ? ctrl_reg : (statHit ? statWord : 8'h00);

	always_comb begin
		ctrl_next = ctrl_reg;
		if (regWrite && ctrlHit) begin
			ctrl_next = (regWdata & ~`SMS_CTRL_RO_MASK) | `SMS_CTRL_RO_MASK;
		end
	end

	always_ff @(posedge sys_clk) begin
		// Hardware standby resets every module but RAM
		if (srst || state_reg == SMS_HW) begin // [R11]
			ctrl_reg <= `SMS_CTRL_RST;
			regRdata_reg <= 8'h00;
		end else begin
			ctrl_reg <= ctrl_next;
			regRdata_reg <= regRead ? rdMux : 8'h00;
		end
	end

	assign regRdata = regRdata_reg;

	// ************************************************************
	// Wake sources
	// ************************************************************
	wire nmiRise = nmiLevel && !nmiPrev_reg;
	wire nmiFall = !nmiLevel && nmiPrev_reg;
	wire nmiEvent = nmi_edge_select ? nmiRise : nmiFall; // [R07]
	wire wakeReq = nmiEvent || (|irqActive); // [R02]

	// ************************************************************
	// Settle counter
	// ************************************************************
	logic [`SMS_CNT_W-1:0] settleCnt_reg;
	logic [`SMS_CNT_W-1:0] settleCnt_next;
	logic [`SMS_CNT_W-1:0] settleLoad;

	always_comb begin
		case (settle_time_select) // [R03]
			3'h0: settleLoad = `SMS_CNT_W'(WAIT_SEL0 - 1);
			3'h1: settleLoad = `SMS_CNT_W'(WAIT_SEL1 - 1);
			3'h2: settleLoad = `SMS_CNT_W'(WAIT_SEL2 - 1);
			3'h3: settleLoad = `SMS_CNT_W'(WAIT_SEL3 - 1);
			3'h4, 3'h5: settleLoad = `SMS_CNT_W'(WAIT_SEL4 - 1);
			default: settleLoad = `SMS_CNT_W'(WAIT_SEL6 - 1);
		endcase
	end

	wire settleDone = (settleCnt_reg == '0);

	always_comb begin
		settleCnt_next = settleCnt_reg;
		if (state_reg == SMS_SOFT && wakeReq) begin
			settleCnt_next = settleLoad; // [R20]
		end else if (state_reg == SMS_SETTLE && !settleDone) begin
			settleCnt_next = settleCnt_reg - `SMS_CNT_W'(1); // [R20]
		end
	end

	// ************************************************************
	// Mode sequencer
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		if (!hwPinHigh) begin
			state_next = SMS_HW; // [R10]
		end else if (!initPinHigh) begin
			state_next = SMS_INIT; // [R15]
		end else begin
			case (state_reg)
				SMS_RUN: begin
					if (sleepExec) begin
						state_next = soft_sleep_enable ? SMS_SOFT : SMS_SLEEP; // [R01]
					end
				end
				SMS_SLEEP: begin
					if (wakeReq) begin
						state_next = SMS_RUN;
					end
				end
				SMS_SOFT: begin
					if (wakeReq) begin
						state_next = SMS_SETTLE; // [R08]
					end
				end
				SMS_SETTLE: begin
					if (settleDone) begin
						state_next = SMS_RUN; // [R20]
					end
				end
				SMS_HW: state_next = SMS_INIT;
				SMS_INIT: state_next = SMS_RUN; // [R17]
				default: state_next = SMS_RUN;
			endcase
		end
	end

	wire leaveWait = (state_reg == SMS_SLEEP || state_reg == SMS_SETTLE) && state_next == SMS_RUN;
	wire leaveInit = state_reg == SMS_INIT && state_next == SMS_RUN;
	logic intExc_reg;
	logic resetExc_reg;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_reg <= SMS_INIT;
			settleCnt_reg <= '0;
			intExc_reg <= 1'b0;
			resetExc_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			settleCnt_reg <= settleCnt_next;
			intExc_reg <= leaveWait; // [R02]
			resetExc_reg <= leaveInit; // [R17]
		end
	end

	// ************************************************************
	// Mode outputs
	// ************************************************************
	wire inSoft = (state_reg == SMS_SOFT);
	wire inSettle = (state_reg == SMS_SETTLE);
	wire inHw = (state_reg == SMS_HW);
	wire inInit = (state_reg == SMS_INIT);

	// ************************************************************
	// RAM retention
	// ************************************************************
	// RAM enable is sampled before hardware standby clears the control register
	logic ramKeep_reg;
	wire ramKeep_next = inHw ? ramKeep_reg : !onchip_ram_enable;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ramKeep_reg <= 1'b0;
		end else begin
			ramKeep_reg <= ramKeep_next; // [R11]
		end
	end


	assign modeState = state_reg;
	assign clockRun = !(inSoft || inSettle || inHw); // [R01]
	assign oscEnable = !(inSoft || inHw); // [R15]
	assign cpuHalt = (state_reg != SMS_RUN); // [R11]
	assign dmaReset = inSoft || inSettle || inHw || inInit; // [R01]
	assign moduleReset = dmaReset;
	assign ioHold = inSoft || inSettle; // [R09]
	assign ioRelease = inHw; // [R12]
	assign ramHold = inSoft || inSettle || (inHw && ramKeep_reg);
	assign intExcStart = intExc_reg;
	assign resetExcStart = resetExc_reg;

	// ************************************************************
	// Checks
	// ************************************************************
	sequence seqWakeShort;
		inSoft && wakeReq && settle_time_select == 3'h6 && hwPinHigh && initPinHigh;
	endsequence

	sequence seqSettleFour;
		inSettle [*4] ##1 (state_reg == SMS_RUN && intExcStart);
	endsequence

	chk_soft_halts_clock: assert property (@(posedge sys_clk) disable iff (srst) // [R01]
		inSoft |-> (!clockRun && cpuHalt && dmaReset && moduleReset && ramHold))
		else $error("soft standby does not halt clock and reset modules");
	chk_settle_wait_len: assert property (@(posedge sys_clk) disable iff (srst || !hwPinHigh || !initPinHigh) // [R02]
		seqWakeShort |=> seqSettleFour)
		else $error("short settle wait not four cycles");
	chk_settle_load_val: assert property (@(posedge sys_clk) disable iff (srst) // [R03]
		(inSoft && wakeReq && settle_time_select == 3'h0 && hwPinHigh && initPinHigh)
		|=> (inSettle && settleCnt_reg == `SMS_CNT_W'(WAIT_SEL0 - 1)))
		else $error("settle count not loaded with selected wait");
	chk_nmi_fall_wake: assert property (@(posedge sys_clk) disable iff (srst) // [R07]
		(inSoft && !nmi_edge_select && nmiFall && hwPinHigh && initPinHigh) |=> inSettle)
		else $error("falling NMI did not wake from soft standby");
	chk_nmi_rise_wake: assert property (@(posedge sys_clk) disable iff (srst) // [R08]
		(inSoft && nmi_edge_select && nmiRise && hwPinHigh && initPinHigh) |=> inSettle)
		else $error("rising NMI did not wake from soft standby");
	chk_soft_io_hold: assert property (@(posedge sys_clk) disable iff (srst) // [R09]
		(inSoft || inSettle) |-> (ioHold && !ioRelease))
		else $error("ports not held in soft standby");
	chk_hw_pin_entry: assert property (@(posedge sys_clk) disable iff (srst) // [R10]
		!hwPinHigh |=> inHw)
		else $error("standby pin low did not enter hardware standby");
	chk_hw_reset_all: assert property (@(posedge sys_clk) disable iff (srst) // [R11]
		inHw |=> (ctrl_reg == `SMS_CTRL_RST && cpuHalt && dmaReset))
		else $error("hardware standby did not reset modules");
	chk_hw_port_release: assert property (@(posedge sys_clk) disable iff (srst) // [R12]
		inHw |-> (ioRelease && !clockRun && !oscEnable))
		else $error("ports not released in hardware standby");
	chk_init_osc_start: assert property (@(posedge sys_clk) disable iff (srst) // [R15]
		(inHw && hwPinHigh && !initPinHigh) |=> (inInit && oscEnable && clockRun))
		else $error("oscillator not started with reset still low");
	chk_reset_exc_start: assert property (@(posedge sys_clk) disable iff (srst) // [R17]
		(inInit && hwPinHigh && initPinHigh) |=> (resetExcStart && state_reg == SMS_RUN) ##1 !resetExcStart)
		else $error("reset handling not started on reset rise");
	chk_sleep_clock_runs: assert property (@(posedge sys_clk) disable iff (srst) // [R01]
		(state_reg == SMS_SLEEP) |-> (clockRun && cpuHalt && !dmaReset && !ioHold))
		else $error("sleep mode stopped the clock or reset modules");
	chk_sleep_wake_exc: assert property (@(posedge sys_clk) disable iff (srst) // [R02]
		(state_reg == SMS_SLEEP && wakeReq && hwPinHigh && initPinHigh) |=> (state_reg == SMS_RUN && intExcStart))
		else $error("wake from sleep did not start interrupt handling");
	chk_hw_ram_keep: assert property (@(posedge sys_clk) disable iff (srst) // [R11]
		(!inHw && !onchip_ram_enable && !hwPinHigh) |=> (inHw && ramHold))
		else $error("RAM not held in hardware standby with enable cleared");
endmodule

// ==== pkg/sms_cfg.svh ====
// Offsets, field positions, reset values and wait counts of the standby sequencer
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH
`define SMS_AW 8
`define SMS_DW 8
`define SMS_OFF_CTRL 8'h00
`define SMS_OFF_STAT 8'h04
`define SMS_CTRL_RST 8'h0b
`define SMS_B_SOFT_SLEEP 7
`define SMS_F_SETTLE_HI 6
`define SMS_F_SETTLE_LO 4
`define SMS_B_NMI_EDGE 2
`define SMS_B_RAM_EN 0
`define SMS_CTRL_RO_MASK 8'h02
`define SMS_CNT_W 18
`define SMS_WAIT_SEL0 8192
`define SMS_WAIT_SEL1 16384
`define SMS_WAIT_SEL2 32768
`define SMS_WAIT_SEL3 65536
`define SMS_WAIT_SEL4 131072
`define SMS_WAIT_SEL6 4
`define SMS_SYNC_W 6
`endif

// ==== pkg/sms_pkg.sv ====
// Types of the standby sequencer
package sms_pkg;
	typedef enum logic [5:0] {
		SMS_RUN = 6'b000001,
		SMS_SLEEP = 6'b000010,
		SMS_SOFT = 6'b000100,
		SMS_SETTLE = 6'b001000,
		SMS_HW = 6'b010000,
		SMS_INIT = 6'b100000
	} sms_state_t;
	typedef logic [2:0] sms_settle_sel_t;
endpackage

// ==== dv/sms_pin_ctrl.sv ====
// Model of the external controller that drives the standby and reset pins
`timescale 1ns/100ps
module sms_pin_ctrl #(
	parameter int HOLD = 20
) (
	input wire logic sys_clk,
	input wire logic goStandby,
	output logic hw_sleep_pin_n,
	output logic chip_init_pin_n
);
	// Mode pins are not modelled and so never change in standby
	initial begin
		hw_sleep_pin_n = 1'b1;
		chip_init_pin_n = 1'b1;
		forever begin
			wait (goStandby);
			@(posedge sys_clk);
			chip_init_pin_n <= 1'b0;
			repeat (4) @(posedge sys_clk);
			hw_sleep_pin_n <= 1'b0;
			wait (!goStandby);
			@(posedge sys_clk);
			hw_sleep_pin_n <= 1'b1;
			repeat (HOLD) @(posedge sys_clk);
			chip_init_pin_n <= 1'b1;
		end
	end
endmodule

// ==== dv/sms_standby_seq_test.sv ====
// Self-checking bench for the standby sequencer
`include "sms_cfg.svh"
`timescale 1ns/100ps
module sms_standby_seq_test;
import sms_pkg::*;
logic sys_clk, srst, regWrite, regRead, sleepExec, nmiPin, goStandby;
logic [7:0] regAddr, regWdata, regRdata, ctl, flags;
logic [2:0] irqEnable, irqPinN;
logic hw_sleep_pin_n, chip_init_pin_n;
sms_state_t modeState;
logic clockRun, oscEnable, cpuHalt, dmaReset, moduleReset, ioHold, ioRelease, ramHold, intExcStart, resetExcStart;
int num_errors = 0;
int total_checks = 0;
int n;
// Short waits stand in for the long settle counts
int waits[8] = '{8, 12, 16, 20, 24, 24, 4, 4};
assign flags = {clockRun, oscEnable, cpuHalt, dmaReset, moduleReset, ioHold, ioRelease, ramHold};
sms_standby_seq #(.WAIT_SEL0(8), .WAIT_SEL1(12), .WAIT_SEL2(16), .WAIT_SEL3(20), .WAIT_SEL4(24)) u_dut (
	.sys_clk, .srst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .sleepExec, .irqEnable, .nmiPin,
	.irqPinN, .hw_sleep_pin_n, .chip_init_pin_n, .modeState, .clockRun, .oscEnable, .cpuHalt, .dmaReset,
	.moduleReset, .ioHold, .ioRelease, .ramHold, .intExcStart, .resetExcStart);
sms_pin_ctrl u_pins (.sys_clk, .goStandby, .hw_sleep_pin_n, .chip_init_pin_n);
// ********
// Tasks
// ********
task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
	total_checks++;
	if (seen !== exp) begin
		num_errors++;
		$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
	end
endtask
task automatic regWr(input logic [7:0] a, input logic [7:0] d);
	@(posedge sys_clk);
	regAddr <= a;
	regWdata <= d;
	regWrite <= 1'b1;
	@(posedge sys_clk);
	regWrite <= 1'b0;
endtask
task automatic regRd(input logic [7:0] a, input logic [7:0] exp);
	@(posedge sys_clk);
	regAddr <= a;
	regRead <= 1'b1;
	@(posedge sys_clk);
	regRead <= 1'b0;
	@(negedge sys_clk);
	check("regRdata", regRdata, exp);
endtask
task automatic sleepNow;
	@(posedge sys_clk);
	sleepExec <= 1'b1;
	@(posedge sys_clk);
	sleepExec <= 1'b0;
	repeat (3) @(negedge sys_clk);
endtask
task automatic waitState(input sms_state_t st, input int lim);
	for (int i = 0; i < lim && modeState !== st; i++) @(negedge sys_clk);
	check("state", {2'b00, modeState}, {2'b00, st});
endtask
task automatic final_report;
	$display("Checks %0d mismatches %0d", total_checks, num_errors);
	if (num_errors == 0 && total_checks > 0) begin
		$display("TB: PASS");
	end else begin
		$display("TB: FAIL");
	end
	$finish;
endtask
// ********
// Tests
// ********
initial begin
	sys_clk = 1'b0;
	forever #5 sys_clk = ~sys_clk;
end
initial begin
	repeat (6000) @(posedge sys_clk);
	num_errors++;
	final_report();
end
initial begin
	{srst, regWrite, regRead, sleepExec, nmiPin, goStandby} = 6'h20;
	{regAddr, regWdata, irqEnable, irqPinN} = {16'h0, 3'h0, 3'h7};
	repeat (20) @(posedge sys_clk);
	srst <= 1'b0;
	waitState(SMS_RUN, 4);
	regRd(`SMS_OFF_CTRL, `SMS_CTRL_RST);
	regWr(`SMS_OFF_STAT, 8'hff);
	regRd(`SMS_OFF_STAT, 8'h01);
	regRd(8'h08, 8'h00);
	$display("Test registers done");
	for (int s = 0; s < 8; s++) begin
		ctl = {1'b1, 3'(s), 1'b0, 1'(s), 1'b0, 1'b1};
		@(posedge sys_clk);
		nmiPin <= ctl[2];
		regWr(`SMS_OFF_CTRL, ctl);
		regRd(`SMS_OFF_CTRL, ctl | 8'h02);
		sleepNow();
		check("flags", flags, 8'h3d);
		@(posedge sys_clk);
		nmiPin <= ~ctl[2];
		repeat (6) @(negedge sys_clk);
		check("state", {2'b00, modeState}, {2'b00, SMS_SOFT});
		@(posedge sys_clk);
		nmiPin <= ctl[2];
		n = 0;
		for (int i = 0; i < 100 && intExcStart !== 1'b1; i++) begin
			@(negedge sys_clk);
			n += int'(modeState === SMS_SETTLE);
		end
		check("wait", 8'(n), 8'(waits[s]));
		check("flags", flags, 8'hc0);
		@(negedge sys_clk);
		check("intExc", {7'h0, intExcStart}, 8'h00);
	end
	$display("Test soft standby done");
	regWr(`SMS_OFF_CTRL, 8'h01);
	sleepNow();
	check("flags", flags, 8'he0);
	@(posedge sys_clk);
	irqPinN <= 3'b101;
	repeat (6) @(negedge sys_clk);
	check("state", {2'b00, modeState}, {2'b00, SMS_SLEEP});
	@(posedge sys_clk);
	irqEnable <= 3'b010;
	waitState(SMS_RUN, 8);
	check("intExc", {7'h0, intExcStart}, 8'h01);
	@(posedge sys_clk);
	irqPinN <= 3'b111;
	$display("Test sleep wake done");
	regWr(`SMS_OFF_CTRL, 8'h80);
	@(posedge sys_clk);
	goStandby <= 1'b1;
	waitState(SMS_HW, 40);
	check("flags", flags, 8'h3b);
	@(posedge sys_clk);
	goStandby <= 1'b0;
	waitState(SMS_INIT, 10);
	check("flags", flags, 8'hf8);
	for (n = 0; n < 60 && resetExcStart !== 1'b1; n++) @(negedge sys_clk);
	check("state", {2'b00, modeState}, {2'b00, SMS_RUN});
	regRd(`SMS_OFF_CTRL, `SMS_CTRL_RST);
	$display("Test hardware standby done");
	final_report();
end
endmodule
